/* rtl/first_request_output_flag_pkg.sv */
package first_request_output_flag_pkg;

   // Raw event sources, one bit per flag, in the same bit order as the status words.
   typedef struct packed {
      logic       rate_conv1_lock;       // Bit 7, lock indication of the first converter.
      logic       under_rate;            // Bit 6, underclocked error condition.
      logic       over_rate;             // Bit 5, overclocked error condition.
      logic       rsvd4;                 // Bit 4, unused.
      logic       loop2_lock;            // Bit 3, second loop lock status.
      logic       loop1_lock;            // Bit 2, first loop lock status.
      logic       main_clock_slow;       // Bit 1, main clock underclocked.
      logic       second_clock_slow;     // Bit 0, secondary clock underclocked.
   } lock_low_t;

   typedef struct packed {
      logic [7:0] rsvd15_8;              // Upper byte belongs to other sources.
      lock_low_t  lo;                    // Lock and clock error sources.
   } lock_word_t;

   typedef struct packed {
      logic [2:0] rsvd15_13;             // Unused.
      logic       host_port_error;       // Bit 12, control interface error.
      logic       mixer_sample_loss;     // Bit 11, mixer dropped a sample.
      logic       second_clock_ena;      // Bit 10, secondary clock enable; falling edge sets.
      logic       main_clock_ena;        // Bit 9, main clock enable; falling edge sets.
      logic [2:0] rate_conv_cfg_error;   // Bits 8..6, converters a, b, c.
      logic [5:0] phones_on;             // Bits 5..0, 3R, 3L, 2R, 2L, 1R, 1L enable complete.
   } event_word_t;

   typedef struct packed {
      logic [6:0] rsvd15_9;              // Unused.
      logic       boot_complete;         // Bit 8, boot sequence finished.
      logic [1:0] rsvd7_6;               // Unused.
      logic       adc_overrange;         // Bit 5, converter overflow.
      logic       adc_buffer_fault;      // Bit 4, converter buffer over or underflow.
      logic       async_conv_cfg_error;  // Bit 3, asynchronous converter config error.
      logic       rsvd2;                 // Unused.
      logic       loop2_clock_valid;     // Bit 1, second loop clock valid.
      logic       loop1_clock_valid;     // Bit 0, first loop clock valid.
   } boot_word_t;

   typedef struct packed {
      logic       shared_mem_collision;  // Bit 15, shared memory write collision.
      logic       speaker_off;           // Bit 14, speaker shutdown status.
      logic       speaker_right_short;   // Bit 13, right speaker short.
      logic       speaker_left_short;    // Bit 12, left speaker short.
      logic [5:0] phones_short;          // Bits 11..6, 3R neg/pos, 3L neg/pos, 2R neg/pos.
      logic [5:0] rsvd5_0;               // Lower bits belong to another block.
   } fault_word_t;

   // All four words; word 3 sits in the low sixteen bits.
   typedef struct packed {
      fault_word_t w6;
      boot_word_t  w5;
      event_word_t w4;
      lock_word_t  w3;
   } event_words_t;

   // Classic Wishbone request and answer.
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [31:0] adr;
      logic [31:0] dat;
   } wb_req_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } wb_rsp_t;

   // Edge selection per flag, word 3 lowest.
   localparam logic [63:0] RISE_SETS = 64'hffc0_013b_19ff_00ef;
   localparam logic [63:0] FALL_SETS = 64'h7000_0003_0600_008c;
   localparam logic [63:0] DEFINED   = RISE_SETS | FALL_SETS;
   localparam logic [63:0] FLAG_RST  = 64'h0000_0000_0000_0000;
   localparam logic [63:0] MASK_RST  = 64'hffc0_003b_1fff_00ef;
   localparam logic        GMASK_RST = 1'h0;

   // Register indices; the byte address is four times the index.
   localparam logic [3:0][13:0] STATUS_IDX = {14'h0d05, 14'h0d04, 14'h0d03, 14'h0d02};
   localparam logic [3:0][13:0] MASK_IDX   = {14'h0d0d, 14'h0d0c, 14'h0d0b, 14'h0d0a};
   localparam logic [13:0]      CTRL_IDX   = 14'h0d0f;
   localparam logic [13:0]      REQ_IDX    = 14'h0d0e;
   localparam int               GMASK_BIT  = 0;

endpackage

/* rtl/flag_edge_capture.sv */
`timescale 1ns/1ps
`default_nettype none

// Synchronises every source, detects the selected edges and keeps the sticky flags.
module flag_edge_capture (
   input  wire logic        i_clk,    // System clock.
   input  wire logic        i_rstn,   // Asynchronous reset, active low.
   input  wire logic [63:0] i_src,    // Raw source levels.
   input  wire logic [63:0] i_clr,    // One-cycle clear pulses, one per flag.
   output var  logic [63:0] o_flags   // Sticky flags.
);

   logic [63:0] meta_q;   // First synchroniser stage, read only by the second.
   logic [63:0] sync_q;   // Second stage, safe to use.
   logic [63:0] prev_q;   // Delayed copy for edge detection.
   logic [63:0] event_d;  // Selected edges this cycle.
   logic [63:0] flags_d;  // Next flag value.

   // Two flops before any logic so that a slow or glitch-free source edge counts once.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         meta_q <= first_request_output_flag_pkg::FLAG_RST;
         sync_q <= first_request_output_flag_pkg::FLAG_RST;
         prev_q <= first_request_output_flag_pkg::FLAG_RST;
      end else begin
         meta_q <= i_src;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // Set wins over clear, and undefined positions never store anything.
   always_comb begin
      event_d = (sync_q & ~prev_q & first_request_output_flag_pkg::RISE_SETS)
              | (~sync_q & prev_q & first_request_output_flag_pkg::FALL_SETS);
      flags_d = ((o_flags & ~i_clr) | event_d) & first_request_output_flag_pkg::DEFINED;
   end

   // The flags hold until cleared, whatever the source does afterwards.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_flags <= first_request_output_flag_pkg::FLAG_RST;
      end else begin
         o_flags <= flags_d;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   a_set_beats_clear: assert property ((event_d & i_clr) != 64'h0000_0000_0000_0000
      |=> (o_flags & $past(event_d)) == $past(event_d))
      else $error("event lost under a simultaneous clear");
   a_flags_latch: assert property (1'b1
      |=> (o_flags & $past(o_flags & ~i_clr)) == $past(o_flags & ~i_clr))
      else $error("flag dropped without a clear");
   a_undef_zero: assert property ((o_flags & ~first_request_output_flag_pkg::DEFINED) == 64'h0000_0000_0000_0000)
      else $error("undefined flag position set");

endmodule // flag_edge_capture

`default_nettype wire

/* rtl/first_request_output_status_flag_bank.sv */
`timescale 1ns/1ps
`default_nettype none

module first_request_output_status_flag_bank (
   input  wire logic                         i_clk,           // System clock, 25 MHz.
   input  wire logic                         i_rstn,          // Asynchronous reset, active low.
   input  wire first_request_output_flag_pkg::wb_req_t       i_wb,            // Wishbone request.
   output var  first_request_output_flag_pkg::wb_rsp_t       o_wb,            // Wishbone answer.
   input  wire first_request_output_flag_pkg::event_words_t  i_src,           // Raw event sources.
   output var  first_request_output_flag_pkg::event_words_t  o_flags,         // Sticky flags, for observation.
   output var  logic                         o_first_request  // Request output, active high.
);

   // A word index match also demands a word-aligned address with nothing above bit 15.
   function automatic logic reg_hit(input logic [31:0] adr, input logic [13:0] idx);
      reg_hit = (adr[31:16] == 16'h0000) && (adr[15:2] == idx) && (adr[1:0] == 2'h0);
   endfunction

   // Byte lanes 0 and 1 cover the sixteen register bits; lanes 2 and 3 hit nothing.
   function automatic logic [15:0] lane_mask(input logic [3:0] sel);
      lane_mask = {{8{sel[1]}}, {8{sel[0]}}};
   endfunction

   logic [63:0] flag_vec;     // Flags as a flat vector.
   logic [63:0] clr_d;        // Clear pulses towards the capture stage.
   logic [63:0] mask_q;       // Per-flag mask bits.
   logic        gmask_q;      // Global request mask.
   logic        ack_q;        // Bus acknowledge.
   logic [31:0] rdat_q;       // Registered read data.
   logic [15:0] rd_word;      // Selected register for a read.
   logic        pending;      // Any unmasked flag set.
   logic        req_q;        // Registered request output.
   logic        bus_req;      // Master is asking.
   logic        wr_commit;    // Write takes effect this edge.
   logic        rd_start;     // First cycle of an access; read data is sampled.
   logic [15:0] lanes;        // Byte enables widened to bits.

   // Bus strobes and the byte-lane mask are shared by every register.
   always_comb begin
      bus_req   = i_wb.cyc & i_wb.stb;
      wr_commit = bus_req & i_wb.we & ack_q;
      rd_start  = bus_req & ~ack_q;
      lanes     = lane_mask(i_wb.sel);
   end

   // Clears only fire on the edge at which the master sees the acknowledge.
   always_comb begin
      clr_d = 64'h0000_0000_0000_0000;
      for (int k = 0; k < 4; k++) begin
         if (wr_commit && reg_hit(i_wb.adr, first_request_output_flag_pkg::STATUS_IDX[k])) begin
            // Only ones clear, and only where the word defines a flag.
            clr_d[k*16 +: 16] = i_wb.dat[15:0] & lanes
                              & first_request_output_flag_pkg::DEFINED[k*16 +: 16];
         end
      end
   end

   // The edge capture stage holds all flags; it is the only state that sources touch.
   // Its rise and fall selections give each flag its own edge, or both edges where a flag is in both selections.
   // The remaining source positions are in neither selection and never set a flag.
   flag_edge_capture u_capture (
      .i_clk   (i_clk),
      .i_rstn  (i_rstn),
      .i_src   (i_src),
      .i_clr   (clr_d),
      .o_flags (flag_vec)
   );

   assign o_flags = first_request_output_flag_pkg::event_words_t'(flag_vec);

   // Mask registers keep undefined positions at zero so they read back as zero.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         mask_q <= first_request_output_flag_pkg::MASK_RST;
      end else begin
         for (int k = 0; k < 4; k++) begin
            if (wr_commit && reg_hit(i_wb.adr, first_request_output_flag_pkg::MASK_IDX[k])) begin
               // Lanes not enabled keep their old value.
               mask_q[k*16 +: 16] <= ((mask_q[k*16 +: 16] & ~lanes)
                                    | (i_wb.dat[15:0] & lanes))
                                    & first_request_output_flag_pkg::DEFINED[k*16 +: 16];
            end
         end
      end
   end

   // Global mask lives in the low lane of the control word.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         gmask_q <= first_request_output_flag_pkg::GMASK_RST;
      end else if (wr_commit && i_wb.sel[0] && reg_hit(i_wb.adr, first_request_output_flag_pkg::CTRL_IDX)) begin
         gmask_q <= i_wb.dat[first_request_output_flag_pkg::GMASK_BIT];
      end
   end

   // Read selection; an unmapped address answers with zero.
   always_comb begin
      rd_word = 16'h0000;
      for (int k = 0; k < 4; k++) begin
         if (reg_hit(i_wb.adr, first_request_output_flag_pkg::STATUS_IDX[k])) begin
            rd_word = flag_vec[k*16 +: 16];
         end
         if (reg_hit(i_wb.adr, first_request_output_flag_pkg::MASK_IDX[k])) begin
            rd_word = mask_q[k*16 +: 16];
         end
      end
      if (reg_hit(i_wb.adr, first_request_output_flag_pkg::CTRL_IDX)) begin
         rd_word = {15'h0000, gmask_q};
      end
      if (reg_hit(i_wb.adr, first_request_output_flag_pkg::REQ_IDX)) begin
         // Bit 1 shows pending work even while the global mask hides it.
         rd_word = {14'h0000, pending, req_q};
      end
   end

   // One wait state: acknowledge follows the first cycle of the request and drops after one.
   // This also guarantees the acknowledge is never held across two back-to-back accesses.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ack_q  <= 1'h0;
         rdat_q <= 32'h0000_0000;
      end else begin
         ack_q <= rd_start;
         if (rd_start) begin
            rdat_q <= {16'h0000, rd_word};
         end
      end
   end

   assign o_wb = '{ack: ack_q, dat: rdat_q};

   // Request output is registered so that it never glitches on a mask write.
   always_comb begin
      pending = |(flag_vec & ~mask_q);
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         req_q <= 1'h0;
      end else begin
         req_q <= pending & ~gmask_q;
      end
   end

   assign o_first_request = req_q;

   // Checks on source-to-flag timing: a change sampled at one edge shows three edges later.
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   // Write of a one to the converter lock flag, seen at the committing edge.
   sequence s_conv1_clear;
      wr_commit && i_wb.sel[0] && i_wb.dat[7]
         && reg_hit(i_wb.adr, first_request_output_flag_pkg::STATUS_IDX[0]);
   endsequence

   // Source held still long enough that no edge is in flight.
   sequence s_conv1_quiet;
      $stable(i_src.w3.lo.rate_conv1_lock) [*3];
   endsequence

   a_conv1_both_edges: assert property ($changed(i_src.w3.lo.rate_conv1_lock)
      |-> ##3 o_flags.w3.lo.rate_conv1_lock)
      else $error("converter lock edge did not set its flag");
   a_under_rise_set: assert property ($rose(i_src.w3.lo.under_rate)
      |-> ##3 o_flags.w3.lo.under_rate)
      else $error("underclock rise did not set its flag");
   a_loop1_lock_fall: assert property ($fell(i_src.w3.lo.loop1_lock)
      |-> ##3 o_flags.w3.lo.loop1_lock)
      else $error("loop lock fall did not set its flag");
   a_main_slow_rise: assert property ($rose(i_src.w3.lo.main_clock_slow)
      |-> ##3 o_flags.w3.lo.main_clock_slow)
      else $error("main clock slow rise missed");
   a_host_port_rise: assert property ($rose(i_src.w4.host_port_error)
      |-> ##3 o_flags.w4.host_port_error)
      else $error("host port error rise missed");
   a_mixer_loss_rise: assert property ($rose(i_src.w4.mixer_sample_loss)
      |-> ##3 o_flags.w4.mixer_sample_loss)
      else $error("mixer sample loss rise missed");
   a_second_clk_off: assert property ($fell(i_src.w4.second_clock_ena)
      |-> ##3 o_flags.w4.second_clock_ena)
      else $error("secondary clock shutdown missed");
   a_main_clk_off: assert property ($fell(i_src.w4.main_clock_ena)
      |-> ##3 o_flags.w4.main_clock_ena)
      else $error("main clock shutdown missed");
   a_boot_rise_set: assert property ($rose(i_src.w5.boot_complete)
      |-> ##3 o_flags.w5.boot_complete)
      else $error("boot complete rise missed");
   a_speaker_off_fall: assert property ($fell(i_src.w6.speaker_off)
      |-> ##3 o_flags.w6.speaker_off)
      else $error("speaker shutdown fall missed");
   a_conv1_w1c_clear: assert property (s_conv1_quiet ##0 s_conv1_clear
      |=> !o_flags.w3.lo.rate_conv1_lock)
      else $error("write of one did not clear the flag");
   a_request_level: assert property (##1 o_first_request
      == $past((|(flag_vec & ~mask_q)) && !gmask_q))
      else $error("request output does not follow unmasked flags");
   a_global_mask: assert property (gmask_q [*2] |-> !o_first_request)
      else $error("request output active under global mask");
   a_ack_pulse: assert property (ack_q |=> !ack_q)
      else $error("acknowledge held longer than one cycle");

endmodule // first_request_output_status_flag_bank

`default_nettype wire

/* verif/host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Host software as seen from the register port: classic single Wishbone cycles.
module host_model (
   input  wire logic                   i_clk,  // System clock.
   input  wire first_request_output_flag_pkg::wb_rsp_t i_rsp,  // Answer from the flag bank.
   output var  first_request_output_flag_pkg::wb_req_t o_req   // Request towards the flag bank.
);
   int unsigned wait_limit = 64;      // Bound on one ack wait, far above the one wait state.
   logic        timed_out  = 1'b0;    // Raised when an ack never came.

   // The bus is idle from time zero, so nothing is taken during reset.
   initial begin
      o_req = '0;
   end

   // One transfer: the request is held from one edge until ack is sampled high.
   // A write of one clears a flag and a zero leaves it alone, so host data is sent as given.
   task automatic xfer(input logic we, input logic [13:0] idx, input logic [15:0] wdat,
                       output logic [15:0] rdat);
      int n;
      n = 0;
      @(posedge i_clk);
      o_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h3,
                 adr: {16'h0000, idx, 2'b00}, dat: {16'h0000, wdat}};
      do begin
         @(posedge i_clk);
         n++;
      end while (i_rsp.ack !== 1'b1 && n < wait_limit);
      if (i_rsp.ack !== 1'b1) begin
         timed_out = 1'b1;
      end
      rdat = i_rsp.dat[15:0];
      // Released only after the ack edge, so cyc stays low for at least one cycle.
      o_req <= '0;
   endtask

endmodule // host_model

`default_nettype wire

/* verif/first_request_output_status_flag_bank_test.sv */
`timescale 1ns/1ps
`default_nettype none

// Self-checking bench for the first request flag bank.
module first_request_output_status_flag_bank_test;
   localparam int CYCLE_LIMIT = 20000;  // The full run needs about 2000 cycles.

   logic                        clk;              // 25 MHz system clock.
   logic                        rst_n;            // Reset, active low.
   first_request_output_flag_pkg::wb_req_t      wb_req;           // Bus request from the host model.
   first_request_output_flag_pkg::wb_rsp_t      wb_rsp;           // Bus answer.
   first_request_output_flag_pkg::event_words_t src;              // Raw sources.
   first_request_output_flag_pkg::event_words_t flags;            // Sticky flags, one bit compared directly.
   logic                        request;          // Request output.
   logic [31:0]                 exp_q[$];         // Expected read data, oldest first.
   logic [15:0]                 rd;               // Data returned by a transfer.
   int                          n_mismatch  = 0;  // Mismatches seen.
   int                          comparisons = 0;  // Comparisons made.
   int                          cycles      = 0;  // Cycle count for the hang guard.

   first_request_output_status_flag_bank uut (
      .i_clk           (clk),
      .i_rstn          (rst_n),
      .i_wb            (wb_req),
      .o_wb            (wb_rsp),
      .i_src           (src),
      .o_flags         (flags),
      .o_first_request (request)
   );

   host_model u_host (
      .i_clk (clk),
      .i_rsp (wb_rsp),
      .o_req (wb_req)
   );

   // Free-running clock, 40 ns period.
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // One comparison; a mismatch is reported at once.
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Reads note their expectation first; the monitor below compares on ack.
   task automatic rd_reg(input logic [13:0] idx, input logic [15:0] exp);
      exp_q.push_back({16'h0000, exp});
      u_host.xfer(1'b0, idx, 16'h0000, rd);
   endtask

   task automatic wr_reg(input logic [13:0] idx, input logic [15:0] dat);
      u_host.xfer(1'b1, idx, dat, rd);
   endtask

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Verdict and end of run; every path out of the bench comes here.
   task automatic finish_test();
      if (u_host.timed_out || exp_q.size() != 0) begin
         n_mismatch++;
      end
      $display("Summary: %0d mismatches in %0d comparisons", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Read data is taken at the ack edge and matched against the oldest note.
   always @(posedge clk) begin
      if (wb_req.cyc && !wb_req.we && wb_rsp.ack === 1'b1) begin
         if (exp_q.size() == 0) begin
            n_mismatch++;
            $display("ERROR at %0t: got %h expected %h", $time, wb_rsp.dat, 32'h0000_0000);
         end else begin
            check(wb_rsp.dat, exp_q.pop_front());
         end
      end
   end

   // Hang guard: a run that overstays its budget counts as a mismatch.
   always @(posedge clk) begin
      cycles++;
      if (cycles == CYCLE_LIMIT) begin
         n_mismatch++;
         finish_test();
      end
   end

   // Main sequence.
   initial begin
      int          b;
      int          k;
      logic [15:0] bit_v;
      logic [31:0] r;
      rst_n = 1'b0;
      src   = '0;
      void'($urandom(83));
      wait_clk(12);
      rst_n <= 1'b1;
      // Reset values of every word, and an unmapped place reads zero.
      for (k = 0; k < 4; k++) begin
         rd_reg(first_request_output_flag_pkg::STATUS_IDX[k], 16'h0000);
         rd_reg(first_request_output_flag_pkg::MASK_IDX[k], first_request_output_flag_pkg::MASK_RST[16*k +: 16]);
      end
      rd_reg(first_request_output_flag_pkg::CTRL_IDX, 16'h0000);
      rd_reg(first_request_output_flag_pkg::REQ_IDX, 16'h0000);
      rd_reg(14'h0d09, 16'h0000);
      // Every source position, rise then fall, with a zero written over the live flag.
      for (b = 0; b < 64; b++) begin
         k     = b / 16;
         bit_v = 16'h0001 << (b % 16);
         @(posedge clk);
         src[b] <= 1'b1;
         wait_clk(6);
         wr_reg(first_request_output_flag_pkg::STATUS_IDX[k], ~bit_v);
         rd_reg(first_request_output_flag_pkg::STATUS_IDX[k],
                first_request_output_flag_pkg::RISE_SETS[b] ? bit_v : 16'h0000);
         wr_reg(first_request_output_flag_pkg::STATUS_IDX[k], bit_v);
         @(posedge clk);
         src[b] <= 1'b0;
         wait_clk(6);
         rd_reg(first_request_output_flag_pkg::STATUS_IDX[k],
                first_request_output_flag_pkg::FALL_SETS[b] ? bit_v : 16'h0000);
         wr_reg(first_request_output_flag_pkg::STATUS_IDX[k], bit_v);
      end
      // A short boot pulse: the flag stays and is the only one passed by default masks.
      @(posedge clk);
      src.w5.boot_complete <= 1'b1;
      wait_clk(3);
      src.w5.boot_complete <= 1'b0;
      wait_clk(8);
      check({31'h0000_0000, request}, 32'h0000_0001);
      rd_reg(first_request_output_flag_pkg::REQ_IDX, 16'h0003);
      wr_reg(first_request_output_flag_pkg::CTRL_IDX, 16'h0001);
      rd_reg(first_request_output_flag_pkg::CTRL_IDX, 16'h0001);
      rd_reg(first_request_output_flag_pkg::REQ_IDX, 16'h0002);
      check({31'h0000_0000, request}, 32'h0000_0000);
      wr_reg(first_request_output_flag_pkg::CTRL_IDX, 16'h0000);
      wait_clk(2);
      check({31'h0000_0000, request}, 32'h0000_0001);
      wr_reg(first_request_output_flag_pkg::STATUS_IDX[2], 16'h0100);
      wait_clk(2);
      check({31'h0000_0000, request}, 32'h0000_0000);
      // Random mask patterns keep only the defined bits, then all masks are closed.
      for (k = 0; k < 4; k++) begin
         r = $urandom;
         wr_reg(first_request_output_flag_pkg::MASK_IDX[k], r[15:0]);
         rd_reg(first_request_output_flag_pkg::MASK_IDX[k], r[15:0] & first_request_output_flag_pkg::DEFINED[16*k +: 16]);
         wr_reg(first_request_output_flag_pkg::MASK_IDX[k], 16'hffff);
      end
      // A random rising source behind its own open mask drives the request.
      do begin
         b = $urandom_range(63, 0);
      end while (!first_request_output_flag_pkg::RISE_SETS[b]);
      k     = b / 16;
      bit_v = 16'h0001 << (b % 16);
      wr_reg(first_request_output_flag_pkg::MASK_IDX[k], ~bit_v);
      @(posedge clk);
      src[b] <= 1'b1;
      wait_clk(8);
      check({31'h0000_0000, request}, 32'h0000_0001);
      check({31'h0000_0000, flags[b]}, 32'h0000_0001);
      wr_reg(first_request_output_flag_pkg::MASK_IDX[k], 16'hffff);
      wait_clk(2);
      check({31'h0000_0000, request}, 32'h0000_0000);
      rd_reg(first_request_output_flag_pkg::STATUS_IDX[k], bit_v);
      // A fresh rising edge lands on the very edge at which a clear commits.
      src[b] <= 1'b0;
      wait_clk(6);
      wr_reg(first_request_output_flag_pkg::STATUS_IDX[k], bit_v);
      @(posedge clk);
      src[b] <= 1'b1;
      wr_reg(first_request_output_flag_pkg::STATUS_IDX[k], bit_v);
      rd_reg(first_request_output_flag_pkg::STATUS_IDX[k], bit_v);
      wait_clk(2);
      finish_test();
   end

endmodule // first_request_output_status_flag_bank_test

`default_nettype wire
